// [src/lsr_lane_steer.sv]
// module: little-endian byte lane steering and beat splitting for the external bus
`timescale 1ns/1ps
module lsr_lane_steer (
   input  wire  logic                    core_clk,
   input  wire  logic                    rstn,
   input  wire  logic                    req_valid,
   output logic                          req_ready,
   input  wire  lsr_pkg::lsr_req_s       req,
   output logic                          beat_valid,
   input  wire  logic                    beat_ready,
   output lsr_pkg::lsr_beat_s            beat,
   input  wire  logic [31:0]             beat_rdata,
   output logic                          rsp_valid,
   input  wire  logic                    rsp_ready,
   output logic [63:0]                   rsp_rdata,
   output logic [3:0]                    write_enable_lane,
   output logic [3:0]                    column_strobe_lane,
   output logic [3:0]                    data_mask_lane
);
   import lsr_pkg::*;

   lsr_state_s s_reg;
   lsr_state_s s_next;
   lsr_beat_s  first_beat;
   lsr_beat_s  step_beat;
   logic [31:0] rd_lane;

   // ************************************************************************
   // beat construction
   // ************************************************************************
   function automatic logic [31:0] lsr_byte_mask(input logic [3:0] m);
      lsr_byte_mask = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction : lsr_byte_mask

   function automatic lsr_beat_s lsr_make_beat(input lsr_req_s r, input logic [2:0] i);
      logic [1:0]  blog;
      logic [2:0]  pos;
      logic [31:0] a;
      logic [1:0]  ln;
      logic [3:0]  m;
      logic [63:0] ch;
      lsr_beat_s   b;
      // one beat carries the smaller of access size and device width
      blog = (r.size > r.width) ? r.width : r.size;
      pos  = 3'(i << blog);
      a    = r.addr + {29'h0, pos};
      case (r.width)
         LSR_W32: ln = a[1:0];
         LSR_W16: ln = {1'b0, a[0]};
         default: ln = 2'h0;
      endcase
      case (blog)
         2'h0:    m = 4'h1;
         2'h1:    m = 4'h3;
         default: m = LSR_STB_ALL;
      endcase
      ch       = r.wdata >> {pos, 3'h0};
      b.addr   = a;
      // unstrobed lanes are driven zero, and reads drive nothing
      b.data   = r.write ? ((ch[31:0] & lsr_byte_mask(m)) << {ln, 3'h0}) : 32'h0;
      b.strobe = 4'(m << ln);
      b.lane   = ln;
      b.mask   = m;
      b.pos    = pos;
      b.write  = r.write;
      lsr_make_beat = b;
   endfunction : lsr_make_beat

   function automatic logic [2:0] lsr_last_idx(input lsr_req_s r);
      logic [1:0] d;
      d = 2'(r.size - r.width);
      if (r.size > r.width) begin
         lsr_last_idx = 3'((4'h1 << d) - 4'h1);
      end else begin
         lsr_last_idx = LSR_IDX_RST;
      end
   endfunction : lsr_last_idx

   // ************************************************************************
   // sequencer
   // ************************************************************************
   always_comb begin
      s_next     = s_reg;
      first_beat = lsr_make_beat(req, LSR_IDX_RST);
      step_beat  = lsr_make_beat(s_reg.req, 3'(s_reg.idx + 3'h1));
      // only strobed lanes of the returned word count
      rd_lane    = (beat_rdata >> {s_reg.beat.lane, 3'h0}) & lsr_byte_mask(s_reg.beat.mask);
      case (s_reg.st)
         LSR_IDLE: begin
            if (req_valid) begin
               s_next.st    = LSR_BUSY;
               s_next.req   = req;
               s_next.idx   = LSR_IDX_RST;
               s_next.last  = lsr_last_idx(req);
               s_next.rdata = 64'h0;
               s_next.beat  = first_beat;
            end
         end
         LSR_BUSY: begin
            if (beat_ready) begin
               if (!s_reg.beat.write) begin
                  s_next.rdata = s_reg.rdata | ({32'h0, rd_lane} << {s_reg.beat.pos, 3'h0});
               end
               if (s_reg.idx == s_reg.last) begin
                  s_next.st = LSR_RESP;
               end else begin
                  // lower addresses and lower significance go first
                  s_next.idx  = 3'(s_reg.idx + 3'h1);
                  s_next.beat = step_beat;
               end
            end
         end
         LSR_RESP: begin
            if (rsp_ready) begin
               s_next.st = LSR_IDLE;
            end
         end
         default: begin
            s_next = LSR_STATE_RST;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s_reg <= LSR_STATE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ************************************************************************
   // outputs
   // ************************************************************************
   assign req_ready  = (s_reg.st == LSR_IDLE);
   assign beat_valid = (s_reg.st == LSR_BUSY);
   assign beat       = s_reg.beat;
   assign rsp_valid  = (s_reg.st == LSR_RESP);
   assign rsp_rdata  = s_reg.rdata;

   // the same lane position feeds whichever strobe family the area uses
   genvar g;
   generate
      for (g = 0; g < LSR_LANES; g++) begin : g_lane
         logic on;
         assign on = beat_valid & s_reg.beat.strobe[g];
         assign write_enable_lane[g]  = on & s_reg.beat.write &
                                        (s_reg.req.iface == LSR_SRAM);
         assign column_strobe_lane[g] = on & (s_reg.req.iface == LSR_DRAM);
         assign data_mask_lane[g]     = on & (s_reg.req.iface == LSR_SDRAM);
      end
   endgenerate

   // ************************************************************************
   // checks
   // ************************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_taken;
      beat_valid && beat_ready && (s_reg.idx != s_reg.last);
   endsequence

   // a full-width step moves four bytes up in the quadword
   sequence s_next_beat;
      beat_valid && (beat.pos == $past(beat.pos) + 3'h4);
   endsequence

   sequence s_req_taken;
      req_valid && req_ready;
   endsequence

   sequence s_last_taken;
      beat_valid && beat_ready && (s_reg.idx == s_reg.last);
   endsequence

   // the far side may stall, so a beat has to stand untouched
   sequence s_beat_wait;
      beat_valid && !beat_ready;
   endsequence

   AST_BYTE32_LANE: assert property (beat_valid && s_reg.req.width == LSR_W32 &&
      s_reg.req.size == LSR_BYTE |-> beat.strobe == (4'h1 << s_reg.req.addr[1:0]))
      else $error("byte lane wrong on 32-bit device");
   AST_WORD32_LANE: assert property (beat_valid && s_reg.req.width == LSR_W32 &&
      s_reg.req.size == LSR_WORD |-> beat.strobe == (s_reg.req.addr[1] ? 4'hC : 4'h3))
      else $error("word lanes wrong on 32-bit device");
   AST_LONG32_ONE: assert property (req_valid && req_ready && req.width == LSR_W32 &&
      req.size == LSR_LONG |=> beat_valid && beat.strobe == 4'hF && s_reg.last == 3'h0)
      else $error("longword not single full cycle");
   AST_QUAD32_ORDER: assert property (s_taken and (s_reg.req.width == LSR_W32)
      |=> s_next_beat ##0 beat.addr == $past(beat.addr) + 32'h4)
      else $error("quadword halves out of order");
   AST_BYTE16_LANE: assert property (beat_valid && s_reg.req.width == LSR_W16 &&
      s_reg.req.size == LSR_BYTE |-> beat.strobe == (s_reg.req.addr[0] ? 4'h2 : 4'h1))
      else $error("byte lane wrong on 16-bit device");
   AST_W16_UPPER: assert property (s_reg.req.width == LSR_W16 |->
      beat.strobe[3:2] == 2'h0 && write_enable_lane[3:2] == 2'h0)
      else $error("upper strobe on 16-bit device");
   AST_W16_SPLIT: assert property (s_taken and (s_reg.req.width == LSR_W16)
      |=> beat.addr == $past(beat.addr) + 32'h2 && beat.strobe == 4'h3)
      else $error("16-bit split step wrong");
   AST_W8_LANE0: assert property (beat_valid && s_reg.req.width == LSR_W8 |->
      beat.strobe == 4'h1 && beat.data[31:8] == 24'h0)
      else $error("8-bit device off lane 0");
   AST_W8_SPLIT: assert property (s_taken and (s_reg.req.width == LSR_W8)
      |=> beat.addr == $past(beat.addr) + 32'h1 && beat.pos == $past(beat.pos) + 3'h1)
      else $error("8-bit split step wrong");
   AST_QUAD8_COUNT: assert property (req_valid && req_ready && req.width == LSR_W8 &&
      req.size == LSR_QUAD |=> s_reg.last == 3'h7 && s_reg.idx == 3'h0)
      else $error("quadword on 8-bit not eight beats");
   AST_FAMILY_ONE: assert property (beat_valid |-> $onehot0({|write_enable_lane,
      |column_strobe_lane, |data_mask_lane}) &&
      (!(|data_mask_lane) || s_reg.req.iface == LSR_SDRAM))
      else $error("strobe family mismatch");
   AST_UNUSED_ZERO: assert property (beat_valid |->
      (beat.data & ~lsr_byte_mask(beat.strobe)) == 32'h0)
      else $error("unstrobed lane driven");

   // ************************************************************************
   // beat budget per access
   // ************************************************************************
   // written out per port width rather than derived, so a wrong shift in the
   // sequencer's last index cannot agree with itself
   logic [3:0] exp_beats;

   always_comb begin
      exp_beats = 4'h1;
      case (s_reg.req.width)
         LSR_W32: begin
            if (s_reg.req.size == LSR_QUAD) begin
               exp_beats = 4'h2;
            end
         end
         LSR_W16: begin
            case (s_reg.req.size)
               LSR_LONG: exp_beats = 4'h2;
               LSR_QUAD: exp_beats = 4'h4;
               default:  exp_beats = 4'h1;
            endcase
         end
         default: begin
            case (s_reg.req.size)
               LSR_WORD: exp_beats = 4'h2;
               LSR_LONG: exp_beats = 4'h4;
               LSR_QUAD: exp_beats = 4'h8;
               default:  exp_beats = 4'h1;
            endcase
         end
      endcase
   end

   AST_BEAT_COUNT: assert property (beat_valid |->
      4'({1'b0, s_reg.last} + 4'h1) == exp_beats)
      else $error("beat count wrong for size and width");

   // ************************************************************************
   // handshake and data checks
   // ************************************************************************
   // the first beat always starts at the request address, lowest byte first
   AST_FIRST_BEAT: assert property (s_req_taken |=> beat_valid &&
      beat.addr == $past(req.addr) && beat.pos == 3'h0)
      else $error("first beat not at request address");
   AST_BEAT_HOLD: assert property (s_beat_wait |=> beat_valid && $stable(beat))
      else $error("beat changed before taken");
   AST_LAST_RESP: assert property (s_last_taken |=> rsp_valid && !beat_valid)
      else $error("extra beat after last");
   AST_RESP_HOLD: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_rdata))
      else $error("response dropped before taken");
   AST_LONG16_FIRST: assert property (s_req_taken and (req.width == LSR_W16 &&
      req.size == LSR_LONG && req.write) |=> beat.data[15:0] == $past(req.wdata[15:0]))
      else $error("16-bit longword low half not first");
   AST_LONG32_DATA: assert property (beat_valid && beat.write &&
      s_reg.req.width == LSR_W32 && s_reg.req.size == LSR_LONG |->
      beat.data == s_reg.req.wdata[31:0])
      else $error("longword not mapped straight");
   AST_QUAD32_HIGH: assert property (s_taken and (s_reg.req.width == LSR_W32 &&
      s_reg.beat.write) |=> beat.data == $past(s_reg.req.wdata[63:32]))
      else $error("quadword high half wrong");

   // ************************************************************************
   // strobe family checks
   // ************************************************************************
   // reads leave the data lanes quiet and never pulse a write enable
   AST_READ_QUIET: assert property (beat_valid && !beat.write |->
      beat.data == 32'h0 && write_enable_lane == 4'h0)
      else $error("read drives data or write enable");
   AST_STB_IDLE: assert property (!beat_valid |-> write_enable_lane == 4'h0 &&
      column_strobe_lane == 4'h0 && data_mask_lane == 4'h0)
      else $error("strobe outside bus cycle");
   AST_WE_MATCH: assert property (beat_valid && beat.write &&
      s_reg.req.iface == LSR_SRAM |-> write_enable_lane == beat.strobe)
      else $error("write enables differ from strobes");
   AST_CS_MATCH: assert property (beat_valid && s_reg.req.iface == LSR_DRAM |->
      column_strobe_lane == beat.strobe)
      else $error("column strobes differ from strobes");
   AST_DM_MATCH: assert property (beat_valid && s_reg.req.iface == LSR_SDRAM |->
      data_mask_lane == beat.strobe)
      else $error("data masks differ from strobes");

endmodule : lsr_lane_steer

// [src/lsr_pkg.sv]
// package: types and constants for the little-endian lane steering block
// ****************************************************************************
// ****************************************************************************
package lsr_pkg;

   localparam int unsigned LSR_LANES    = 4;
   localparam logic [3:0]  LSR_STB_NONE = 4'h0;
   localparam logic [3:0]  LSR_STB_ALL  = 4'hF;
   localparam logic [2:0]  LSR_IDX_RST  = 3'h0;

   typedef enum logic [1:0] {LSR_BYTE = 2'h0, LSR_WORD = 2'h1,
                             LSR_LONG = 2'h2, LSR_QUAD = 2'h3} lsr_size_e;
   typedef enum logic [1:0] {LSR_W8 = 2'h0, LSR_W16 = 2'h1, LSR_W32 = 2'h2} lsr_width_e;
   typedef enum logic [1:0] {LSR_SRAM = 2'h0, LSR_DRAM = 2'h1, LSR_SDRAM = 2'h2} lsr_iface_e;
   typedef enum logic [1:0] {LSR_IDLE = 2'h0, LSR_BUSY = 2'h1, LSR_RESP = 2'h3} lsr_st_e;

   typedef struct packed {
      logic        write;
      lsr_size_e   size;
      lsr_width_e  width;
      lsr_iface_e  iface;
      logic [31:0] addr;
      logic [63:0] wdata;
   } lsr_req_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  strobe;
      logic [1:0]  lane;
      logic [3:0]  mask;
      logic [2:0]  pos;
      logic        write;
   } lsr_beat_s;

   typedef struct packed {
      lsr_st_e     st;
      lsr_req_s    req;
      logic [2:0]  idx;
      logic [2:0]  last;
      logic [63:0] rdata;
      lsr_beat_s   beat;
   } lsr_state_s;

   localparam lsr_req_s   LSR_REQ_RST  = '{write: 1'b0, size: LSR_BYTE, width: LSR_W32,
                                          iface: LSR_SRAM, addr: 32'h0, wdata: 64'h0};
   localparam lsr_beat_s  LSR_BEAT_RST = '{addr: 32'h0, data: 32'h0, strobe: 4'h0,
                                          lane: 2'h0, mask: 4'h0, pos: 3'h0, write: 1'b0};
   localparam lsr_state_s LSR_STATE_RST = '{st: LSR_IDLE, req: LSR_REQ_RST,
                                           idx: 3'h0, last: 3'h0, rdata: 64'h0,
                                           beat: LSR_BEAT_RST};

endpackage : lsr_pkg

// [test/lsr_mem_model.sv]
// partner model: external memory answering bus cycles after a set stall
`timescale 1ns/1ps
module lsr_mem_model (
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire logic               beat_valid,
   input  wire lsr_pkg::lsr_beat_s beat,
   input  wire logic [1:0]         width,
   input  wire logic [3:0]         stall,
   output logic                    beat_ready,
   output logic [31:0]             beat_rdata
);
   import lsr_pkg::*;
   logic [3:0]  wait_cnt;
   logic [31:0] base;
   assign base = beat.addr & ~((32'h1 << width) - 32'h1);
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wait_cnt   <= 4'h0;
         beat_ready <= 1'b0;
         beat_rdata <= 32'h0;
      end else if (!beat_valid || beat_ready) begin
         wait_cnt   <= 4'h0;
         beat_ready <= 1'b0;
         beat_rdata <= ~beat_rdata;  // released bus must not hold old data
      end else if (wait_cnt == stall) begin
         beat_ready <= 1'b1;
         for (int k = 0; k < 4; k++) begin
            // lanes past the port width carry junk, so reads must ignore them
            beat_rdata[8*k +: 8] <= (k < (1 << width)) ? base[7:0] + 8'(k) + 8'h30
                                    : ~beat_rdata[8*k +: 8];
         end
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : lsr_mem_model

// [test/lsr_lane_steer_test.sv]
// testbench: little-endian lane steering against a memory model
`timescale 1ns/1ps
module lsr_lane_steer_test;
   import lsr_pkg::*;
   localparam logic [63:0] WD = 64'hF0E1D2C3B4A59687;
   logic core_clk, rstn, req_valid, req_ready, beat_valid, beat_ready, rsp_valid, rsp_ready;
   lsr_req_s    req;
   lsr_beat_s   beat;
   logic [31:0] beat_rdata;
   logic [63:0] rsp_rdata;
   logic [3:0]  we, cs, dm, stall;
   logic [1:0]  bus_width;
   int          failures, check_count, spin;
   lsr_lane_steer dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .beat_valid(beat_valid), .beat_ready(beat_ready),
      .beat(beat), .beat_rdata(beat_rdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_rdata(rsp_rdata), .write_enable_lane(we), .column_strobe_lane(cs),
      .data_mask_lane(dm));
   lsr_mem_model mem (.core_clk(core_clk), .rstn(rstn), .beat_valid(beat_valid),
      .beat(beat), .width(bus_width), .stall(stall), .beat_ready(beat_ready),
      .beat_rdata(beat_rdata));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // ************************************************************
   // helpers
   // ************************************************************
   task test_done;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // every wait after the reset phase goes through here so a hang ends the run
   task tick;
      @(negedge core_clk);
      spin++;
      if (spin > 60) begin
         $display("Error at %0t: wait ran out", $time);
         failures++;
         test_done();
      end
   endtask : tick
   task automatic access(input logic wr, input lsr_size_e sz, input lsr_width_e wd,
                         input lsr_iface_e ifc, input logic [31:0] a);
      int nb, bb, ln;
      logic [63:0] rexp;
      logic [31:0] dexp;
      logic [3:0]  sexp;
      nb = 1 << sz;
      bb = (nb < (1 << wd)) ? nb : (1 << wd);
      rexp = 64'h0;
      req = '{write: wr, size: sz, width: wd, iface: ifc, addr: a, wdata: WD};
      bus_width = wd;
      req_valid = 1'b1;
      spin = 0;
      while (req_ready !== 1'b1) tick();
      tick();
      req_valid = 1'b0;
      for (int i = 0; i < nb / bb; i++) begin
         spin = 0;
         while (!(beat_valid === 1'b1 && beat_ready === 1'b1)) tick();
         ln = (a + i * bb) & ((1 << wd) - 1);
         sexp = 4'((1 << bb) - 1) << ln;
         dexp = 32'h0;
         for (int j = 0; j < bb; j++) begin
            if (wr) dexp[8*(ln+j) +: 8] = WD[8*(i*bb+j) +: 8];
            rexp[8*(i*bb+j) +: 8] = 8'(a + i * bb + j) + 8'h30;
         end
         chk(beat.addr, a + i * bb, "address");
         chk(beat.strobe, sexp, "strobe");
         chk(beat.data, dexp, "lane data");
         chk({we, cs, dm}, {(wr && ifc == LSR_SRAM) ? sexp : 4'h0,
             (ifc == LSR_DRAM) ? sexp : 4'h0, (ifc == LSR_SDRAM) ? sexp : 4'h0},
             "lane strobes");
         chk({beat.write, beat.pos, beat.lane, beat.mask},
             {wr, 3'(i * bb), 2'(ln), 4'((1 << bb) - 1)}, "beat fields");
         chk(req_ready, 1'b0, "busy");
         tick();
      end
      spin = 0;
      while (rsp_valid !== 1'b1) tick();
      chk(rsp_rdata, wr ? 64'h0 : rexp, "read data");
      chk(beat_valid, 1'b0, "beat count");
      rsp_ready = 1'b1;
      tick();
      rsp_ready = 1'b0;
   endtask : access
   task automatic sweep(input lsr_width_e wd, input lsr_size_e sz, input logic [31:0] a);
      for (int f = 0; f < 3; f++) begin
         for (int w = 0; w < 2; w++) access(w[0], sz, wd, lsr_iface_e'(f), a);
      end
   endtask : sweep
   // ************************************************************
   // scenarios
   // ************************************************************
   task t_w32;
      for (int o = 0; o < 4; o++) sweep(LSR_W32, LSR_BYTE, 32'h100 + o);
      sweep(LSR_W32, LSR_WORD, 32'h100);
      sweep(LSR_W32, LSR_WORD, 32'h102);
      sweep(LSR_W32, LSR_LONG, 32'h104);
      sweep(LSR_W32, LSR_QUAD, 32'h108);
      $display("t_w32 done");
   endtask : t_w32
   task t_w16;
      sweep(LSR_W16, LSR_BYTE, 32'h200);
      sweep(LSR_W16, LSR_BYTE, 32'h201);
      sweep(LSR_W16, LSR_WORD, 32'h202);
      sweep(LSR_W16, LSR_LONG, 32'h204);
      sweep(LSR_W16, LSR_QUAD, 32'h208);
      $display("t_w16 done");
   endtask : t_w16
   task t_w8;
      sweep(LSR_W8, LSR_BYTE, 32'h303);
      sweep(LSR_W8, LSR_WORD, 32'h306);
      sweep(LSR_W8, LSR_LONG, 32'h30C);
      sweep(LSR_W8, LSR_QUAD, 32'h310);
      $display("t_w8 done");
   endtask : t_w8
   // slow memory: beats must stand until taken, order unchanged
   task t_stall;
      stall = 4'h3;
      sweep(LSR_W16, LSR_QUAD, 32'h418);
      sweep(LSR_W8, LSR_QUAD, 32'h420);
      stall = 4'h0;
      $display("t_stall done");
   endtask : t_stall
   // reset in mid-access: everything drops back to idle on the next rising clock edge
   task t_reset;
      req = '{write: 1'b0, size: LSR_QUAD, width: LSR_W8, iface: LSR_DRAM, addr: 32'h500,
              wdata: WD};
      bus_width = 2'h0;
      req_valid = 1'b1;
      spin = 0;
      tick();
      req_valid = 1'b0;
      repeat (3) tick();
      chk(beat_valid, 1'b1, "busy before reset");
      rstn = 1'b0;
      tick();
      chk({req_ready, beat_valid, rsp_valid, we, cs, dm}, 64'h4000, "mid-run reset");
      chk(rsp_rdata, 64'h0, "read data after reset");
      rstn = 1'b1;
      sweep(LSR_W8, LSR_WORD, 32'h506);
      $display("t_reset done");
   endtask : t_reset
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req = LSR_REQ_RST;
      rsp_ready = 1'b0;
      stall = 4'h0;
      bus_width = 2'h2;
      failures = 0;
      check_count = 0;
      repeat (6) @(negedge core_clk);
      chk({req_ready, beat_valid, rsp_valid, we, cs, dm}, 64'h4000, "reset state");
      rstn = 1'b1;
      t_w32();
      t_w16();
      t_w8();
      t_stall();
      t_reset();
      test_done();
   end
endmodule : lsr_lane_steer_test
